// *** core/uhr_host_regs.sv ***
// usb host interrupt-enable, frame number and pipe address registers on axi4-lite
// Summary of operation
// - writing one to the connection bit of enable-set sets conn_irq_en
// - writing one to the connection bit of enable-clear clears conn_irq_en
// - a one written to enable-clear clears that implemented enable bit
// - zeros written to enable-clear or enable-set change nothing; both read zero
// - a one written to enable-set sets that implemented enable bit
// - layout: dma 7..1 at 31..25, pipes 7..0 at 15..8, events 6..0
// - full speed frame counter length 30000 at 30 MHz; upper byte at 23..16
// - high speed frame counter length 3750 at 30 MHz; upper byte shown
// - 11-bit frame_count at bits 13..3, readable and writable
// - writing frame_count resets microframe_count to zero
// - microframe_count held at zero in full speed
// - address low register holds pipes 0..3, pipe 0 in lowest byte
// - address high register holds pipes 4..7, pipe 4 in lowest byte
// - a usb bus reset request clears every pipe address
// - a pipe flag raises the usb interrupt only while its enable is set
`timescale 1ns/1ns
module uhr_host_regs #(
	parameter logic [15:0] FS_FRAME_LEN = uhr_pkg::FS_FRAME_LEN
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output wire logic s_axi_wready,
	output wire logic [1:0] s_axi_bresp,
	output wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output wire logic s_axi_arready,
	output wire logic [31:0] s_axi_rdata,
	output wire logic [1:0] s_axi_rresp,
	output wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tick_30m,
	input wire logic usb_reset_req,
	input wire logic [31:0] host_irq_flags,
	output wire logic [31:0] host_irq_enable,
	output wire logic [55:0] pipe_dev_addr,
	output wire logic sof_pulse,
	output wire logic usb_irq,
	output wire logic evt_irq
);
	logic awready_r;
	logic aw_held_r;
	logic [11:0] awaddr_r;
	logic wready_r;
	logic w_held_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	localparam int EVT_MSB = uhr_pkg::EVT_W - 1;
	logic [31:0] host_irq_enable_r;
	logic [6:0] addr_r [uhr_pkg::PIPES];
	logic [EVT_MSB:0] evt_stat_r;
	logic [EVT_MSB:0] evt_en_r;
	logic [uhr_pkg::CTRL_W-1:0] ctrl_r;
	logic usb_irq_r;
	logic evt_irq_r;

	logic aw_take;
	logic w_take;
	logic wr_do;
	logic aw_held_nxt;
	logic w_held_nxt;
	logic ar_take;
	logic rvalid_nxt;
	logic [31:0] wmask;
	logic [31:0] wbits;
	logic [31:0] wen_bits;
	logic [31:0] frame_word;
	logic [31:0] frame_new;
	logic [63:0] addr_flat;
	logic [EVT_MSB:0] evt_set;
	logic [31:0] rd_data_c;
	logic rd_ok_c;
	logic wr_ok_c;
	logic irq_hit;
	logic wr_en_clr;
	logic wr_en_set;

	uhr_frm_if frm ();

	uhr_frame_timer #(
		.FS_LEN(FS_FRAME_LEN)
	) u_timer (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.tick_30m(tick_30m),
		.frm(frm)
	);

	// write channel: address and data are caught independently, then applied together
	assign aw_take = s_axi_awvalid && awready_r;
	assign w_take = s_axi_wvalid && wready_r;
	assign wr_do = aw_held_r && w_held_r && !bvalid_r;
	assign aw_held_nxt = aw_held_r ? !wr_do : aw_take;
	assign w_held_nxt = w_held_r ? !wr_do : w_take;
	assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	assign wbits = wdata_r & wmask;
	assign wen_bits = wbits & uhr_pkg::IRQ_EN_IMPL;
	assign wr_en_clr = wr_do && awaddr_r == uhr_pkg::OFS_IRQ_EN_CLR;
	assign wr_en_set = wr_do && awaddr_r == uhr_pkg::OFS_IRQ_EN_SET;

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end
		else
		begin
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			awready_r <= !aw_held_nxt;
			wready_r <= !w_held_nxt;
			if (aw_take)
				awaddr_r <= {s_axi_awaddr[11:2], 2'b00};
			if (w_take)
			begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
		end
	end

	always_comb
	begin
		unique case (awaddr_r)
			uhr_pkg::OFS_IRQ_EN_CLR,
			uhr_pkg::OFS_IRQ_EN_SET,
			uhr_pkg::OFS_FRAME,
			uhr_pkg::OFS_ADDR_LO,
			uhr_pkg::OFS_ADDR_HI,
			uhr_pkg::OFS_EVT_CLR,
			uhr_pkg::OFS_EVT_EN,
			uhr_pkg::OFS_CTRL: wr_ok_c = 1'b1;
			default: wr_ok_c = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= uhr_pkg::RESP_OKAY;
		end
		else if (wr_do)
		begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_ok_c ? uhr_pkg::RESP_OKAY : uhr_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_r <= 1'b0;
	end

	// enable set and clear come from separate writes, so they never collide
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			host_irq_enable_r <= uhr_pkg::RST_ZERO;
		else if (wr_en_clr)
			host_irq_enable_r <= host_irq_enable_r & ~wen_bits;
		else if (wr_en_set)
			host_irq_enable_r <= host_irq_enable_r | wen_bits;
	end

	assign frame_word = {8'h00, frm.frame_len_upper, 2'b00, frm.frame_count, frm.microframe_count};
	assign frame_new = wbits | (frame_word & ~wmask);
	assign frm.wr_frame = wr_do && awaddr_r == uhr_pkg::OFS_FRAME && (|wstrb_r[1:0]);
	assign frm.wr_value = frame_new[uhr_pkg::FRAME_CNT_LSB +: uhr_pkg::FRAME_CNT_W];
	assign frm.hs_mode = ctrl_r[uhr_pkg::CTRL_HS];
	assign frm.run = ctrl_r[uhr_pkg::CTRL_RUN];

	genvar gi;
	generate
		for (gi = 0; gi < uhr_pkg::PIPES; gi++)
		begin : g_pipe
			localparam logic [11:0] OFS = (gi < 4) ? uhr_pkg::OFS_ADDR_LO : uhr_pkg::OFS_ADDR_HI;
			localparam int LANE = gi % 4;
			always_ff @(posedge clk_sys or negedge rstn)
			begin
				if (!rstn)
					addr_r[gi] <= '0;
				else if (usb_reset_req)
					addr_r[gi] <= '0;
				else if (wr_do && awaddr_r == OFS && wstrb_r[LANE])
					addr_r[gi] <= wdata_r[LANE*8 +: uhr_pkg::PIPE_ADDR_W];
			end
			assign addr_flat[gi*8 +: 8] = {1'b0, addr_r[gi]};
			assign pipe_dev_addr[gi*7 +: 7] = addr_r[gi];
		end
	endgenerate

	// bus reset is flagged too, since it silently wipes the pipe addresses
	assign evt_set = {usb_reset_req, frm.sof_pulse};

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			evt_stat_r <= '0;
		else if (wr_do && awaddr_r == uhr_pkg::OFS_EVT_CLR)
			evt_stat_r <= (evt_stat_r & ~wbits[EVT_MSB:0]) | evt_set;
		else
			evt_stat_r <= evt_stat_r | evt_set;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			evt_en_r <= '0;
			ctrl_r <= '0;
		end
		else if (wr_do && awaddr_r == uhr_pkg::OFS_EVT_EN && wstrb_r[0])
			evt_en_r <= wdata_r[EVT_MSB:0];
		else if (wr_do && awaddr_r == uhr_pkg::OFS_CTRL && wstrb_r[0])
			ctrl_r <= wdata_r[uhr_pkg::CTRL_W-1:0];
	end

	assign irq_hit = |(host_irq_flags & host_irq_enable_r);

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			usb_irq_r <= 1'b0;
			evt_irq_r <= 1'b0;
		end
		else
		begin
			usb_irq_r <= irq_hit;
			evt_irq_r <= |(evt_stat_r & evt_en_r);
		end
	end

	// read channel: one read outstanding, answered the cycle after the address is taken
	assign ar_take = s_axi_arvalid && arready_r;
	assign rvalid_nxt = ar_take || (rvalid_r && !s_axi_rready);

	always_comb
	begin
		rd_data_c = uhr_pkg::RST_ZERO;
		rd_ok_c = 1'b1;
		unique case ({s_axi_araddr[11:2], 2'b00})
			uhr_pkg::OFS_IRQ_EN: rd_data_c = host_irq_enable_r;
			uhr_pkg::OFS_IRQ_EN_CLR,
			uhr_pkg::OFS_IRQ_EN_SET,
			uhr_pkg::OFS_EVT_CLR: rd_data_c = uhr_pkg::RST_ZERO;
			uhr_pkg::OFS_FRAME: rd_data_c = frame_word;
			uhr_pkg::OFS_ADDR_LO: rd_data_c = addr_flat[31:0];
			uhr_pkg::OFS_ADDR_HI: rd_data_c = addr_flat[63:32];
			uhr_pkg::OFS_EVT_STAT: rd_data_c[EVT_MSB:0] = evt_stat_r;
			uhr_pkg::OFS_EVT_EN: rd_data_c[EVT_MSB:0] = evt_en_r;
			uhr_pkg::OFS_CTRL: rd_data_c[uhr_pkg::CTRL_W-1:0] = ctrl_r;
			default: rd_ok_c = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= uhr_pkg::RST_ZERO;
			rresp_r <= uhr_pkg::RESP_OKAY;
		end
		else
		begin
			arready_r <= !rvalid_nxt;
			rvalid_r <= rvalid_nxt;
			if (ar_take)
			begin
				rdata_r <= rd_data_c;
				rresp_r <= rd_ok_c ? uhr_pkg::RESP_OKAY : uhr_pkg::RESP_SLVERR;
			end
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign host_irq_enable = host_irq_enable_r;
	assign sof_pulse = frm.sof_pulse;
	assign usb_irq = usb_irq_r;
	assign evt_irq = evt_irq_r;

	en_clear_a:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		wr_en_clr |=> (host_irq_enable_r & $past(wen_bits)) == 32'h0000_0000)
		else $error("enable clear left a bit set");

	en_set_a:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		wr_en_set |=> (host_irq_enable_r & $past(wen_bits)) == $past(wen_bits))
		else $error("enable set left a bit clear");

	conn_set_a:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		(wr_en_set && wbits[0]) ##1 !wr_en_clr [*2] |-> host_irq_enable_r[0])
		else $error("connection enable not set");

	conn_clr_a:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		(wr_en_clr && wbits[0]) |=> !host_irq_enable_r[0])
		else $error("connection enable not cleared");

	zero_keep_a:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		((wr_en_clr || wr_en_set) && wbits == 32'h0000_0000) |=> $stable(host_irq_enable_r))
		else $error("zero write changed the enable register");

	wo_read_a:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		(ar_take && s_axi_araddr == uhr_pkg::OFS_IRQ_EN_SET)
		|=> rvalid_r && rdata_r == 32'h0000_0000)
		else $error("enable set register did not read zero");

	en_reserved_a:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		(host_irq_enable_r & 32'h01FF_0080) == 32'h0000_0000)
		else $error("reserved enable bit set");

	busrst_clr_a:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		usb_reset_req |=> addr_flat == 64'h0000_0000_0000_0000)
		else $error("bus reset did not clear pipe addresses");

	addr_top_a:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		(wr_do && awaddr_r == uhr_pkg::OFS_ADDR_LO && wstrb_r[0] && !usb_reset_req)
		|=> addr_flat[7:0] == {1'b0, $past(wdata_r[6:0])})
		else $error("pipe address load or top bit wrong");

	usb_irq_a:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		##1 usb_irq_r == $past(irq_hit))
		else $error("usb interrupt does not follow enabled flags");
endmodule : uhr_host_regs

// *** core/uhr_pkg.sv ***
// constants for the usb host interrupt-enable, frame and pipe address registers
package uhr_pkg;
	localparam logic [11:0] OFS_IRQ_EN = 12'h410;
	localparam logic [11:0] OFS_IRQ_EN_CLR = 12'h414;
	localparam logic [11:0] OFS_IRQ_EN_SET = 12'h418;
	localparam logic [11:0] OFS_FRAME = 12'h420;
	localparam logic [11:0] OFS_ADDR_LO = 12'h424;
	localparam logic [11:0] OFS_ADDR_HI = 12'h428;
	localparam logic [11:0] OFS_EVT_STAT = 12'h430;
	localparam logic [11:0] OFS_EVT_CLR = 12'h434;
	localparam logic [11:0] OFS_EVT_EN = 12'h438;
	localparam logic [11:0] OFS_CTRL = 12'h43C;
	localparam logic [31:0] IRQ_EN_IMPL = 32'hFE00_FF7F;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam int FRAME_CNT_LSB = 3;
	localparam int FRAME_CNT_W = 11;
	localparam int PIPE_ADDR_W = 7;
	localparam int PIPES = 8;
	localparam int EVT_SOF = 0;
	localparam int EVT_BUSRST = 1;
	localparam int EVT_W = 2;
	localparam int CTRL_HS = 0;
	localparam int CTRL_RUN = 1;
	localparam int CTRL_W = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [2:0] UFRAME_LAST = 3'h7;
	localparam int USB_TICK_MHZ = 30;
	localparam int SOF_FS_US = 1000;
	localparam int SOF_HS_NS = 125000;
	localparam logic [15:0] FS_FRAME_LEN = 16'(SOF_FS_US * USB_TICK_MHZ);
	localparam logic [15:0] HS_FRAME_LEN = 16'(SOF_HS_NS * USB_TICK_MHZ / 1000);
endpackage : uhr_pkg

// *** core/uhr_frm_if.sv ***
// frame timer control and status between register bank and frame timer
`timescale 1ns/1ns
interface uhr_frm_if;
	logic hs_mode;
	logic run;
	logic wr_frame;
	logic [10:0] wr_value;
	logic [10:0] frame_count;
	logic [2:0] microframe_count;
	logic [7:0] frame_len_upper;
	logic sof_pulse;
	modport ctrl(output hs_mode, run, wr_frame, wr_value,
		input frame_count, microframe_count, frame_len_upper, sof_pulse);
	modport timer(input hs_mode, run, wr_frame, wr_value,
		output frame_count, microframe_count, frame_len_upper, sof_pulse);
endinterface : uhr_frm_if

// *** core/uhr_frame_timer.sv ***
// frame length counter, frame number and micro-frame number
`timescale 1ns/1ns
module uhr_frame_timer #(
	parameter logic [15:0] FS_LEN = uhr_pkg::FS_FRAME_LEN
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic tick_30m,
	uhr_frm_if.timer frm
);
	logic [15:0] cnt_r;
	logic [2:0] mfr_r;
	logic [10:0] frame_count_r;
	logic sof_r;
	logic [15:0] len_last;
	logic wrap;

	assign len_last = frm.hs_mode ? uhr_pkg::HS_FRAME_LEN - 16'h0001 : FS_LEN - 16'h0001;
	// >= so a switch to the short length mid-frame still wraps
	assign wrap = frm.run && tick_30m && (cnt_r >= len_last);

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			cnt_r <= '0;
		else if (!frm.run)
			cnt_r <= '0;
		else if (wrap)
			cnt_r <= '0;
		else if (tick_30m)
			cnt_r <= cnt_r + 16'h0001;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			sof_r <= 1'b0;
		else
			sof_r <= wrap;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			mfr_r <= '0;
			frame_count_r <= '0;
		end
		else if (frm.wr_frame)
		begin
			frame_count_r <= frm.wr_value;
			mfr_r <= '0;
		end
		else if (wrap && frm.hs_mode)
		begin
			mfr_r <= mfr_r + 3'h1;
			if (mfr_r == uhr_pkg::UFRAME_LAST)
				frame_count_r <= frame_count_r + 11'h001;
		end
		else if (wrap)
		begin
			mfr_r <= '0;
			frame_count_r <= frame_count_r + 11'h001;
		end
		else if (!frm.hs_mode)
			mfr_r <= '0;
	end

	assign frm.frame_count = frame_count_r;
	assign frm.microframe_count = mfr_r;
	assign frm.frame_len_upper = cnt_r[15:8];
	assign frm.sof_pulse = sof_r;

	fs_mframe_zero_a:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		!frm.hs_mode |=> mfr_r == 3'h0)
		else $error("micro-frame not zero in full speed");

	frame_wr_a:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		frm.wr_frame |=> (mfr_r == 3'h0) && (frame_count_r == $past(frm.wr_value)))
		else $error("frame write did not load number and clear micro-frame");

	fs_wrap_a:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		(frm.run && tick_30m && !frm.hs_mode && cnt_r == FS_LEN - 16'h0001)
		|=> sof_r && cnt_r == 16'h0000)
		else $error("full speed frame did not wrap at its length");

	hs_wrap_a:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		(frm.run && tick_30m && frm.hs_mode && cnt_r == uhr_pkg::HS_FRAME_LEN - 16'h0001)
		|=> sof_r && cnt_r == 16'h0000)
		else $error("high speed frame did not wrap at its length");

	mframe_roll_a:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		(wrap && frm.hs_mode && !frm.wr_frame)
		|=> mfr_r == $past(mfr_r) + 3'h1
		&& frame_count_r == $past(frame_count_r) + (($past(mfr_r) == 3'h7) ? 11'h001 : 11'h000))
		else $error("micro-frame roll did not advance frame number");
endmodule : uhr_frame_timer

// *** sim/uhr_usb_model.sv ***
// usb side stand-in: 30 MHz tick, bus reset request and interrupt flags
`timescale 1ns/1ns
module uhr_usb_model (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic bus_reset_cmd,
	input wire logic [31:0] flags_cmd,
	output logic tick_30m,
	output logic usb_reset_req,
	output logic [31:0] host_irq_flags
);
	logic [3:0] phase_r;
	// three ticks in every ten system cycles gives exactly 30 MHz on average
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			phase_r <= 4'h0;
			tick_30m <= 1'b0;
		end
		else
		begin
			phase_r <= (phase_r == 4'h9) ? 4'h0 : phase_r + 4'h1;
			tick_30m <= (phase_r == 4'h0) || (phase_r == 4'h3) || (phase_r == 4'h6);
		end
	end
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			usb_reset_req <= 1'b0;
			host_irq_flags <= 32'h0000_0000;
		end
		else
		begin
			usb_reset_req <= bus_reset_cmd;
			host_irq_flags <= flags_cmd;
		end
	end
endmodule : uhr_usb_model

// *** sim/usb_host_irq_frame_addr_regs_tb.sv ***
// register bank bench: axi4-lite master, usb side model, self-checking tests
`timescale 1ns/1ns
module usb_host_irq_frame_addr_regs_tb;
	// short full-speed frame keeps the run brief
	localparam logic [15:0] FS_LEN = 16'h0028;
	localparam logic [31:0] IMPL = uhr_pkg::IRQ_EN_IMPL;
	localparam logic [31:0] Z = 32'h0000_0000;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] flags_cmd = 32'h0000_0000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic bus_reset_cmd = 1'b0;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, tick_30m, usb_reset_req;
	logic sof_pulse, usb_irq, evt_irq, ha, hw, hd;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, host_irq_flags, host_irq_enable, v, f1;
	logic [55:0] pipe_dev_addr;
	int mismatches = 0;
	int checks_done = 0;
	int cyc = 0;
	int tick_cnt = 0;
	int last_len = 0;

	always #5 clk_sys = ~clk_sys;

	uhr_usb_model usb (.clk_sys(clk_sys), .rstn(rstn), .bus_reset_cmd(bus_reset_cmd),
		.flags_cmd(flags_cmd), .tick_30m(tick_30m), .usb_reset_req(usb_reset_req),
		.host_irq_flags(host_irq_flags));

	uhr_host_regs #(.FS_FRAME_LEN(FS_LEN)) dut (.clk_sys(clk_sys), .rstn(rstn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .tick_30m(tick_30m),
		.usb_reset_req(usb_reset_req), .host_irq_flags(host_irq_flags),
		.host_irq_enable(host_irq_enable), .pipe_dev_addr(pipe_dev_addr),
		.sof_pulse(sof_pulse), .usb_irq(usb_irq), .evt_irq(evt_irq));

	// ticks seen between two frame starts
	always @(posedge clk_sys)
	begin
		if (sof_pulse)
		begin
			last_len <= tick_cnt;
			tick_cnt <= int'(tick_30m);
		end
		else if (tick_30m)
			tick_cnt <= tick_cnt + 1;
	end

	task automatic close_out;
		$display("mismatches %0d checks_done %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			mismatches++;
			close_out();
		end
	end

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// handshakes are judged on values settled at the falling edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		hd = 1'b0;
		while (!hd)
		begin
			@(negedge clk_sys);
			ha = awvalid & awready;
			hw = wvalid & wready;
			hd = bvalid & bready;
			r = bresp;
			@(posedge clk_sys);
			if (ha)
				awvalid <= 1'b0;
			if (hw)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] a);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		hd = 1'b0;
		while (!hd)
		begin
			@(negedge clk_sys);
			ha = arvalid & arready;
			hd = rvalid & rready;
			v = rdata;
			r = rresp;
			@(posedge clk_sys);
			if (ha)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask : rd

	task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
		rd(a);
		chk(nm, v, e);
	endtask : rchk

	task automatic wsof;
		@(negedge clk_sys);
		while (sof_pulse !== 1'b1)
			@(negedge clk_sys);
		repeat (2) @(negedge clk_sys);
	endtask : wsof

	initial
	begin
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		rchk(12'h420, Z, "frame_rst");
		rchk(12'h424, Z, "addr_lo_rst");
		rchk(12'h428, Z, "addr_hi_rst");
		wr(12'h418, 32'hFFFF_FFFF);
		rchk(12'h410, IMPL, "en_all");
		chk("en_port", host_irq_enable, IMPL);
		wr(12'h414, 32'h0000_0001);
		rchk(12'h410, IMPL & ~32'h0000_0001, "conn_off");
		wr(12'h414, Z);
		wr(12'h418, Z);
		rchk(12'h410, IMPL & ~32'h0000_0001, "zero_wr");
		rchk(12'h414, Z, "clr_read");
		rchk(12'h418, Z, "set_read");
		wr(12'h418, 32'h0000_0001);
		rchk(12'h410, IMPL, "conn_on");
		wr(12'h414, 32'hFFFF_FFFF);
		rchk(12'h410, Z, "en_none");
		wr(12'h500, 32'hFFFF_FFFF);
		chk("unmapped_wr", {30'h0, r}, {30'h0, uhr_pkg::RESP_SLVERR});
		rd(12'h500);
		chk("unmapped_rd", {30'h0, r}, {30'h0, uhr_pkg::RESP_SLVERR});
		flags_cmd <= 32'h0000_0100;
		repeat (4) @(negedge clk_sys);
		chk("irq_masked", {31'h0, usb_irq}, Z);
		wr(12'h418, 32'h0000_0100);
		repeat (3) @(negedge clk_sys);
		chk("irq_on", {31'h0, usb_irq}, 32'h0000_0001);
		wr(12'h414, 32'h0000_0100);
		repeat (3) @(negedge clk_sys);
		chk("irq_off", {31'h0, usb_irq}, Z);
		wr(12'h424, 32'hFFFF_FFFF);
		rchk(12'h424, 32'h7F7F_7F7F, "addr_top");
		wr(12'h424, 32'h0403_0201);
		wr(12'h428, 32'h0807_0605);
		rchk(12'h424, 32'h0403_0201, "addr_lo");
		rchk(12'h428, 32'h0807_0605, "addr_hi");
		chk("pipe0", {25'h0, pipe_dev_addr[6:0]}, 32'h0000_0001);
		chk("pipe3", {25'h0, pipe_dev_addr[27:21]}, 32'h0000_0004);
		chk("pipe4", {25'h0, pipe_dev_addr[34:28]}, 32'h0000_0005);
		chk("pipe7", {25'h0, pipe_dev_addr[55:49]}, 32'h0000_0008);
		wstrb <= 4'h2;
		wr(12'h424, 32'hFFFF_FFFF);
		wstrb <= 4'hF;
		rchk(12'h424, 32'h0403_7F01, "addr_strb");
		bus_reset_cmd <= 1'b1;
		@(posedge clk_sys);
		bus_reset_cmd <= 1'b0;
		rchk(12'h424, Z, "lo_bus_rst");
		rchk(12'h428, Z, "hi_bus_rst");
		wr(12'h43C, 32'h0000_0002);
		wsof();
		wsof();
		chk("fs_len", 32'(last_len), 32'(FS_LEN));
		rd(12'h420);
		f1 = v;
		chk("fs_uframe", {29'h0, f1[2:0]}, Z);
		wsof();
		rd(12'h420);
		chk("fs_next", v & 32'h0000_3FFF, (f1 & 32'h0000_3FFF) + 32'h0000_0008);
		wr(12'h438, 32'h0000_0001);
		repeat (3) @(negedge clk_sys);
		chk("evt_on", {31'h0, evt_irq}, 32'h0000_0001);
		wr(12'h438, Z);
		repeat (3) @(negedge clk_sys);
		chk("evt_masked", {31'h0, evt_irq}, Z);
		wr(12'h438, 32'h0000_0001);
		wr(12'h434, 32'h0000_0001);
		repeat (3) @(negedge clk_sys);
		chk("evt_cleared", {31'h0, evt_irq}, Z);
		wr(12'h43C, 32'h0000_0003);
		wsof();
		wr(12'h420, 32'h0000_0050);
		wsof();
		wsof();
		chk("hs_len", 32'(last_len), 32'(uhr_pkg::HS_FRAME_LEN));
		rd(12'h420);
		chk("hs_frame", v & 32'h0000_3FFF, 32'h0000_0052);
		wr(12'h420, 32'h0000_001D);
		rd(12'h420);
		chk("uframe_zero", v & 32'h0000_3FFF, 32'h0000_0018);
		close_out();
	end
endmodule : usb_host_irq_frame_addr_regs_tb
